// ==== hw/sbm_pkg.sv ====
/*
 Constants of the switch buffer manager control and status registers.
 Assumes a 32-bit AXI4-Lite slave and 8-bit buffer counts from the fabric.
*/
// Functional notes
// R1 - With counter test set, reading a clear-on-read counter loads 7FFF_FFFC.
// R2 - Queue servicing bit set selects fixed priority, clear selects round robin.
// R3 - Three pacing bits enable egress pacing on ports 2, 1 and 0.
// R4 - Yellow discard bit subjects yellow packets to random discard.
// R5 - Red discard bit drops every red packet.
// R6 - With two or three ports active, the low drop level (49h) limits each port.
// R7 - With one port active, the high drop level (64h) limits each port.
// R8 - A port is active at 36 buffers in use; picks low or high sets.
// R9 - All levels count 128-byte buffers.
// R10 - Pause at pause level: 21h low set, 3Ch high set.
// R11 - Pause value 1 is sent at the resume level, low set 03h.
// R12 - High resume level 07h applies with zero or one ports active.
// R13 - Flood traffic buffers are capped at the broadcast level, reset 31h.
// R14 - Port 0 drop counter counts every host port drop of any cause.
// R15 - Reading the port 0 counter returns it and clears it; resets to zero.
// R16 - The drop counter stops at FFFF_FFFF and never wraps.
// R17 - All configuration bits reset cleared.
// R18 - Reserved bits read zero and ignore writes.
// R19 - A packet arriving at use equal to its drop limit is dropped and counted.
package sbm_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [13:0] IDX_CFG = 14'h1C00;
    localparam logic [13:0] IDX_DROP = 14'h1C01;
    localparam logic [13:0] IDX_PAUSE = 14'h1C02;
    localparam logic [13:0] IDX_RESUME = 14'h1C03;
    localparam logic [13:0] IDX_FLOOD = 14'h1C04;
    localparam logic [13:0] IDX_CNT0 = 14'h1C05;

    // ------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] MASK_CFG = 32'h0000007F;
    localparam logic [31:0] MASK_LVL2 = 32'h0000FFFF;
    localparam logic [31:0] MASK_LVL1 = 32'h000000FF;
    localparam logic [31:0] RST_CFG = 32'h00000000;
    localparam logic [31:0] RST_DROP = 32'h00004964;
    localparam logic [31:0] RST_PAUSE = 32'h0000213C;
    localparam logic [31:0] RST_RESUME = 32'h00000307;
    localparam logic [31:0] RST_FLOOD = 32'h00000031;
    localparam logic [31:0] RST_CNT = 32'h00000000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_TEST = 6;
    localparam int CFG_FIXPRI = 5;
    localparam int CFG_PACE_LSB = 2;
    localparam int CFG_YELLOW = 1;
    localparam int CFG_RED = 0;
    localparam int LVL_LOW_LSB = 8;
    localparam int LVL_HIGH_LSB = 0;

    // ------------------------------------------------------------
    // Counter and threshold constants
    // ------------------------------------------------------------
    localparam logic [31:0] CNT_TEST_VAL = 32'h7FFFFFFC;
    localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;
    localparam logic [7:0] ACTIVE_BUFS = 8'h24;
    localparam int BUF_BYTES = 128;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Read channel states
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } sbm_rd_t;

endpackage : sbm_pkg

// ==== hw/sbm_csrs.sv ====
/*
 Buffer manager registers and admission logic: AXI4-Lite slave, drop,
 pause and resume decisions, and the port 0 drop counter.
 Assumes the fabric supplies per-port and flood buffer use in buffers.
*/
`timescale 1ns/1ps
module sbm_csrs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [sbm_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [sbm_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Buffer use from the fabric
    input wire logic [7:0] portUse0,
    input wire logic [7:0] portUse1,
    input wire logic [7:0] portUse2,
    input wire logic [7:0] floodUse,
    // Packet arrival
    input wire logic pktValid,
    input wire logic [1:0] pktPort,
    input wire logic pktYellow,
    input wire logic pktRed,
    input wire logic pktFlood,
    input wire logic randomHit,
    // Decisions and controls
    output logic pktDrop,
    output logic pktAdmit,
    output logic [2:0] pauseReq,
    output logic [2:0] resumeReq,
    output logic [2:0] activePorts,
    output logic fixedPrioMode,
    output logic [2:0] egressPaceEn
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Byte strobes merged into the writable bits only
    function automatic logic [31:0] mergeStrb(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb,
            input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        mergeStrb = ((old & ~m) | (data & m)) & mask;
    endfunction : mergeStrb

    // Low or high half of a level register
    function automatic logic [7:0] selLvl(input logic [31:0] lvl,
            input logic low);
        if (low) begin
            selLvl = lvl[sbm_pkg::LVL_LOW_LSB +: 8];
        end else begin
            selLvl = lvl[sbm_pkg::LVL_HIGH_LSB +: 8];
        end
    endfunction : selLvl

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] cfg, next_cfg;
    logic [31:0] dropLvl, next_dropLvl;
    logic [31:0] pauseLvl, next_pauseLvl;
    logic [31:0] resumeLvl, next_resumeLvl;
    logic [31:0] floodLvl, next_floodLvl;
    logic [31:0] dropCnt, next_dropCnt;
    logic awHeld, next_awHeld;
    logic wHeld, next_wHeld;
    logic [13:0] awIdx, next_awIdx;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrbH, next_wStrbH;
    logic next_awready, next_wready, next_bvalid;
    logic [1:0] next_bresp;
    sbm_pkg::sbm_rd_t rdState, next_rdState;
    logic next_arready, next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic cntRead;
    logic next_pktDrop, next_pktAdmit;
    logic [2:0] next_pauseReq, next_resumeReq, next_activePorts;
    logic dropNow;
    logic [7:0] use3 [3];
    logic [7:0] pktUse;
    logic [1:0] activeCnt;
    logic lowSet;
    logic [7:0] dropLim, pauseLim, resumeLim;

    // Control bits leave straight from the config flops
    assign fixedPrioMode = cfg[sbm_pkg::CFG_FIXPRI]; // see R2
    assign egressPaceEn = cfg[sbm_pkg::CFG_PACE_LSB +: 3]; // see R3
    assign use3[0] = portUse0;
    assign use3[1] = portUse1;
    assign use3[2] = portUse2;

    // ------------------------------------------------------------
    // Bus and registers
    // ------------------------------------------------------------

    // Next values of the bus channels and the register file
    always_comb begin
        next_cfg = cfg;
        next_dropLvl = dropLvl;
        next_pauseLvl = pauseLvl;
        next_resumeLvl = resumeLvl;
        next_floodLvl = floodLvl;
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awIdx = awIdx;
        next_wData = wData;
        next_wStrbH = wStrbH;
        next_bvalid = bvalid && !bready;
        next_bresp = bresp;
        next_rdState = rdState;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        cntRead = 1'b0;
        if (awvalid && awready) begin
            next_awHeld = 1'b1;
            next_awIdx = awaddr[sbm_pkg::ADDR_W-1:2];
        end
        if (wvalid && wready) begin
            next_wHeld = 1'b1;
            next_wData = wdata;
            next_wStrbH = wstrb;
        end
        // Write once address and data are both held
        if (awHeld && wHeld && !bvalid) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = sbm_pkg::RESP_OKAY;
            unique case (awIdx)
                sbm_pkg::IDX_CFG: begin
                    next_cfg = mergeStrb(cfg, wData, wStrbH,
                        sbm_pkg::MASK_CFG); // see R18
                end
                sbm_pkg::IDX_DROP: begin
                    next_dropLvl = mergeStrb(dropLvl, wData, wStrbH,
                        sbm_pkg::MASK_LVL2);
                end
                sbm_pkg::IDX_PAUSE: begin
                    next_pauseLvl = mergeStrb(pauseLvl, wData, wStrbH,
                        sbm_pkg::MASK_LVL2);
                end
                sbm_pkg::IDX_RESUME: begin
                    next_resumeLvl = mergeStrb(resumeLvl, wData, wStrbH,
                        sbm_pkg::MASK_LVL2);
                end
                sbm_pkg::IDX_FLOOD: begin
                    next_floodLvl = mergeStrb(floodLvl, wData, wStrbH,
                        sbm_pkg::MASK_LVL1); // see R18
                end
                sbm_pkg::IDX_CNT0: begin
                    next_bresp = sbm_pkg::RESP_OKAY;
                end
                default: begin
                    next_bresp = sbm_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_awHeld && !next_bvalid;
        next_wready = !next_wHeld && !next_bvalid;
        // Read channel
        unique case (rdState)
            sbm_pkg::RD_IDLE: begin
                if (arvalid && arready) begin
                    next_rdState = sbm_pkg::RD_RESP;
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    next_rresp = sbm_pkg::RESP_OKAY;
                    unique case (araddr[sbm_pkg::ADDR_W-1:2])
                        sbm_pkg::IDX_CFG: next_rdata = cfg;
                        sbm_pkg::IDX_DROP: next_rdata = dropLvl;
                        sbm_pkg::IDX_PAUSE: next_rdata = pauseLvl;
                        sbm_pkg::IDX_RESUME: next_rdata = resumeLvl;
                        sbm_pkg::IDX_FLOOD: next_rdata = floodLvl;
                        sbm_pkg::IDX_CNT0: begin
                            next_rdata = dropCnt;
                            cntRead = 1'b1; // see R15
                        end
                        default: begin
                            next_rdata = 32'h00000000;
                            next_rresp = sbm_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            sbm_pkg::RD_RESP: begin
                if (rready) begin
                    next_rdState = sbm_pkg::RD_IDLE;
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                end
            end
        endcase
        next_arready = next_rdState == sbm_pkg::RD_IDLE; // Address taken only when idle
        // Port 0 drop counter: clear or test load, then a drop still counts
        next_dropCnt = dropCnt;
        if (cntRead) begin
            next_dropCnt = cfg[sbm_pkg::CFG_TEST] ? sbm_pkg::CNT_TEST_VAL
                : 32'h00000000; // see R1 see R15
        end
        if (dropNow && pktPort == 2'h0) begin // see R14 see R19
            if (next_dropCnt != sbm_pkg::CNT_MAX) begin // see R16
                next_dropCnt = next_dropCnt + 32'h00000001;
            end
        end
    end

    // Register stage of the bus and register file
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cfg <= sbm_pkg::RST_CFG; // see R17
            dropLvl <= sbm_pkg::RST_DROP;
            pauseLvl <= sbm_pkg::RST_PAUSE;
            resumeLvl <= sbm_pkg::RST_RESUME;
            floodLvl <= sbm_pkg::RST_FLOOD;
            dropCnt <= sbm_pkg::RST_CNT;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awIdx <= 14'h0000;
            wData <= 32'h00000000;
            wStrbH <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rdState <= sbm_pkg::RD_IDLE;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else begin
            cfg <= next_cfg;
            dropLvl <= next_dropLvl;
            pauseLvl <= next_pauseLvl;
            resumeLvl <= next_resumeLvl;
            floodLvl <= next_floodLvl;
            dropCnt <= next_dropCnt;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awIdx <= next_awIdx;
            wData <= next_wData;
            wStrbH <= next_wStrbH;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rdState <= next_rdState;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ------------------------------------------------------------
    // Admission and flow control
    // ------------------------------------------------------------

    // Threshold set follows the count of active ports, all in buffers
    always_comb begin
        activeCnt = 2'h0;
        for (int p = 0; p < 3; p++) begin
            next_activePorts[p] = use3[p] >= sbm_pkg::ACTIVE_BUFS; // see R8
            activeCnt = activeCnt + {1'b0, next_activePorts[p]};
        end
        lowSet = activeCnt >= 2'h2; // see R6 see R7 see R12
        dropLim = selLvl(dropLvl, lowSet); // see R9
        pauseLim = selLvl(pauseLvl, lowSet); // see R10
        resumeLim = selLvl(resumeLvl, lowSet); // see R11 see R12
        pktUse = (pktPort == 2'h3) ? 8'h00 : use3[pktPort];
        dropNow = pktValid && (
            (pktUse >= dropLim) || // see R6 see R7 see R19
            (pktFlood && floodUse >= floodLvl[7:0]) || // see R13
            (pktRed && cfg[sbm_pkg::CFG_RED]) || // see R5
            (pktYellow && cfg[sbm_pkg::CFG_YELLOW] && randomHit)); // see R4
        next_pktDrop = dropNow;
        next_pktAdmit = pktValid && !dropNow;
        // Pause held from pause level until use falls to resume level
        for (int p = 0; p < 3; p++) begin
            next_pauseReq[p] = pauseReq[p];
            next_resumeReq[p] = 1'b0;
            if (use3[p] >= pauseLim) begin
                next_pauseReq[p] = 1'b1; // see R10
            end else if (pauseReq[p] && use3[p] <= resumeLim) begin
                next_pauseReq[p] = 1'b0;
                next_resumeReq[p] = 1'b1; // see R11
            end
        end
    end

    // Register stage of the decisions
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pktDrop <= 1'b0;
            pktAdmit <= 1'b0;
            pauseReq <= 3'h0;
            resumeReq <= 3'h0;
            activePorts <= 3'h0;
        end else begin
            pktDrop <= next_pktDrop;
            pktAdmit <= next_pktAdmit;
            pauseReq <= next_pauseReq;
            resumeReq <= next_resumeReq;
            activePorts <= next_activePorts;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_cnt_saturates: assert property ( // see R16
        dropCnt == sbm_pkg::CNT_MAX && !cntRead |=> dropCnt == sbm_pkg::CNT_MAX)
        else $error("drop counter wrapped");
    a_read_clears: assert property ( // see R15
        cntRead && !cfg[sbm_pkg::CFG_TEST] && !pktValid |=> dropCnt == 32'h0 && rvalid)
        else $error("counter not cleared by read");
    a_test_load: assert property ( // see R1
        cntRead && cfg[sbm_pkg::CFG_TEST] && !pktValid
        |=> dropCnt == sbm_pkg::CNT_TEST_VAL)
        else $error("test value not loaded");
    a_red_drop: assert property ( // see R5
        pktValid && pktRed && cfg[sbm_pkg::CFG_RED] |=> pktDrop && !pktAdmit)
        else $error("red packet admitted");
    a_limit_drop: assert property ( // see R19
        pktValid && pktUse >= dropLim |=> pktDrop)
        else $error("packet above limit admitted");
    a_drop_counted: assert property ( // see R14
        dropNow && pktPort == 2'h0 && !cntRead && dropCnt != sbm_pkg::CNT_MAX
        |=> dropCnt == $past(dropCnt) + 32'h1)
        else $error("host port drop not counted");
    a_pause_level: assert property ( // see R10
        portUse0 >= pauseLim |=> pauseReq[0])
        else $error("pause not raised");
    a_cfg_reserved: assert property ( // see R18
        (cfg & ~sbm_pkg::MASK_CFG) == 32'h0 && floodLvl[31:8] == 24'h0)
        else $error("reserved bits set");
    a_resume_pulse: assert property ( // see R11
        $rose(resumeReq[0]) |-> $past(pauseReq[0]) && !pauseReq[0])
        else $error("resume without pause");

endmodule : sbm_csrs

// ==== verification/sbm_fabric_model.sv ====
/*
 Behavioural model of the switch fabric ports that feed the buffer manager.
 Assumes the bench calls setUse and sendPkt just after a rising clk_sys edge.
*/
`timescale 1ns/1ps
module sbm_fabric_model (
    // Clock
    input wire logic clk_sys,
    // Buffer use toward the block
    output logic [7:0] portUse0,
    output logic [7:0] portUse1,
    output logic [7:0] portUse2,
    output logic [7:0] floodUse,
    // Packet arrival
    output logic pktValid,
    output logic [1:0] pktPort,
    output logic pktYellow,
    output logic pktRed,
    output logic pktFlood,
    output logic randomHit
);
    // Idle fabric at time zero
    initial begin
        {portUse0, portUse1, portUse2, floodUse} = 32'h00000000;
        {pktValid, pktPort, pktYellow, pktRed, pktFlood, randomHit} = 7'h00;
    end

    // Load new buffer occupancy
    task automatic setUse(input logic [7:0] u0, input logic [7:0] u1,
            input logic [7:0] u2, input logic [7:0] fl);
        portUse0 <= u0;
        portUse1 <= u1;
        portUse2 <= u2;
        floodUse <= fl;
    endtask : setUse

    // One-cycle arrival; qualifiers flip afterwards so stale values never match
    task automatic sendPkt(input logic [1:0] port, input logic y, input logic r,
            input logic fl, input logic hit);
        pktValid <= 1'h1;
        {pktPort, pktYellow, pktRed, pktFlood, randomHit} <= {port, y, r, fl, hit};
        @(posedge clk_sys);
        pktValid <= 1'h0;
        {pktPort, pktYellow, pktRed, pktFlood, randomHit} <= ~{port, y, r, fl, hit};
        @(posedge clk_sys);
    endtask : sendPkt
endmodule : sbm_fabric_model

// ==== verification/test_sbm_csrs.sv ====
/*
 Self-checking bench of the buffer manager registers and admission logic.
 Assumes the fabric model drives occupancy and packets; bench is AXI master.
*/
`timescale 1ns/1ps
module test_sbm_csrs;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_sys, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pktValid, pktYellow, pktRed;
    logic pktFlood, randomHit, pktDrop, pktAdmit, fixedPrioMode;
    logic [sbm_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, pktPort;
    logic [7:0] portUse0, portUse1, portUse2, floodUse;
    logic [2:0] pauseReq, resumeReq, activePorts, egressPaceEn;
    logic [31:0] expRd[$];
    logic [1:0] expPkt[$];
    logic [31:0] cnt0;
    int n_fail, checks_done, n;

    // Design and far-side model
    sbm_csrs DUT (.clk_sys(clk_sys), .nrst(nrst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .portUse0(portUse0), .portUse1(portUse1),
        .portUse2(portUse2), .floodUse(floodUse), .pktValid(pktValid), .pktPort(pktPort),
        .pktYellow(pktYellow), .pktRed(pktRed), .pktFlood(pktFlood), .randomHit(randomHit),
        .pktDrop(pktDrop), .pktAdmit(pktAdmit), .pauseReq(pauseReq), .resumeReq(resumeReq),
        .activePorts(activePorts), .fixedPrioMode(fixedPrioMode), .egressPaceEn(egressPaceEn));
    sbm_fabric_model fab (.clk_sys(clk_sys), .portUse0(portUse0), .portUse1(portUse1),
        .portUse2(portUse2), .floodUse(floodUse), .pktValid(pktValid), .pktPort(pktPort),
        .pktYellow(pktYellow), .pktRed(pktRed), .pktFlood(pktFlood), .randomHit(randomHit));

    // ------------------------------------------------------------
    // Compare, report and bus tasks
    // ------------------------------------------------------------
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : checkWord

    task automatic checkPkt(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : checkPkt

    task automatic results;
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    // Write one word; channels released as each is taken
    task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [3:0] s);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!(bvalid && bready));
    endtask : wr

    // Read one word; the monitor compares the data
    task automatic rd(input logic [13:0] idx, input logic [31:0] e);
        expRd.push_back(e);
        araddr <= {idx, 2'h0};
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid);
    endtask : rd

    // Send a packet and note the expected decision
    task automatic pk(input logic [1:0] p, input logic y, input logic r, input logic fl,
            input logic hit, input logic drop);
        expPkt.push_back(drop ? 2'h2 : 2'h1);
        if (drop && p == 2'h0) cnt0++;
        fab.sendPkt(p, y, r, fl, hit);
    endtask : pk

    task automatic use3(input logic [7:0] u0, input logic [7:0] u1, input logic [7:0] u2);
        fab.setUse(u0, u1, u2, 8'h00);
        repeat (3) @(posedge clk_sys);
    endtask : use3

    // ------------------------------------------------------------
    // Clock, monitor and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Oldest note against each result
    always @(posedge clk_sys) begin
        if (nrst && (pktDrop || pktAdmit))
            checkPkt({pktDrop, pktAdmit}, expPkt.size() ? expPkt.pop_front() : 2'h3);
        if (nrst && rvalid && rready)
            checkWord(rdata, expRd.size() ? expRd.pop_front() : 32'hDEADBEEF);
    end

    initial begin
        repeat (6000) @(posedge clk_sys);
        n_fail++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 68'h0;
        {n_fail, checks_done, cnt0} = 0;
        void'($urandom(32'h3F1D));
        repeat (20) @(posedge clk_sys);
        nrst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        // Reset values and an unmapped word
        rd(sbm_pkg::IDX_CFG, sbm_pkg::RST_CFG);
        rd(sbm_pkg::IDX_DROP, sbm_pkg::RST_DROP);
        rd(sbm_pkg::IDX_PAUSE, sbm_pkg::RST_PAUSE);
        rd(sbm_pkg::IDX_RESUME, sbm_pkg::RST_RESUME);
        rd(sbm_pkg::IDX_FLOOD, sbm_pkg::RST_FLOOD);
        rd(sbm_pkg::IDX_CNT0, 32'h00000000);
        rd(14'h0040, 32'h00000000);
        checkWord({30'h0, rresp}, 32'h00000002);
        wr(14'h0040, 32'hFFFFFFFF, 4'hF);
        checkWord({30'h0, bresp}, 32'h00000002);
        // Reserved bits, byte strobes, control outputs
        wr(sbm_pkg::IDX_CFG, 32'hFFFFFFFF, 4'hF);
        rd(sbm_pkg::IDX_CFG, sbm_pkg::MASK_CFG);
        checkWord({28'h0, fixedPrioMode, egressPaceEn}, 32'h0000000F);
        for (int i = 0; i < 3; i++) begin
            wr(sbm_pkg::IDX_CFG, 32'h00000004 << i, 4'hF);
            repeat (2) @(posedge clk_sys);
            checkWord({28'h0, fixedPrioMode, egressPaceEn}, 32'h00000001 << i);
        end
        wr(sbm_pkg::IDX_DROP, 32'h0000AB00, 4'h2);
        rd(sbm_pkg::IDX_DROP, 32'h0000AB64);
        wr(sbm_pkg::IDX_DROP, 32'hFFFFFFFF, 4'hF);
        rd(sbm_pkg::IDX_DROP, sbm_pkg::MASK_LVL2);
        wr(sbm_pkg::IDX_DROP, sbm_pkg::RST_DROP, 4'hF);
        wr(sbm_pkg::IDX_CFG, 32'h00000000, 4'hF);
        // Drop limits, one then two ports active
        use3(8'h64, 8'h00, 8'h00);
        pk(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        pk(2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
        use3(8'h63, 8'h00, 8'h00);
        pk(2'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        use3(8'h49, 8'h30, 8'h00);
        pk(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        pk(2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        use3(8'h48, 8'h30, 8'h00);
        pk(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        // Colour discard and flood cap
        wr(sbm_pkg::IDX_CFG, 32'h00000003, 4'hF);
        use3(8'h00, 8'h00, 8'h00);
        pk(2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
        pk(2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
        pk(2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        fab.setUse(8'h00, 8'h00, 8'h00, 8'h31);
        repeat (3) @(posedge clk_sys);
        pk(2'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
        for (int i = 0; i < 8; i++) begin
            fab.setUse(8'($urandom_range(35)), 8'($urandom_range(35)),
                8'($urandom_range(35)), 8'($urandom_range(48)));
            repeat (3) @(posedge clk_sys);
            pk(2'($urandom_range(2)), 1'h0, 1'h0, 1'h1, 1'($urandom), 1'h0);
        end
        // Clear on read, then test load
        rd(sbm_pkg::IDX_CNT0, cnt0);
        rd(sbm_pkg::IDX_CNT0, 32'h00000000);
        wr(sbm_pkg::IDX_CFG, 32'h00000040, 4'hF);
        use3(8'h64, 8'h00, 8'h00);
        pk(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        rd(sbm_pkg::IDX_CNT0, 32'h00000001);
        rd(sbm_pkg::IDX_CNT0, sbm_pkg::CNT_TEST_VAL);
        pk(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        wr(sbm_pkg::IDX_CFG, 32'h00000000, 4'hF);
        rd(sbm_pkg::IDX_CNT0, sbm_pkg::CNT_TEST_VAL + 32'h00000001);
        rd(sbm_pkg::IDX_CNT0, 32'h00000000);
        // Pause and resume, both threshold sets
        use3(8'h3C, 8'h00, 8'h00);
        checkWord({29'h0, pauseReq}, 32'h00000001);
        use3(8'h08, 8'h00, 8'h00);
        checkWord({29'h0, pauseReq}, 32'h00000001);
        fab.setUse(8'h07, 8'h00, 8'h00, 8'h00);
        n = 0;
        while (!resumeReq[0] && n < 10) begin
            @(posedge clk_sys);
            n++;
        end
        checkWord({29'h0, resumeReq}, 32'h00000001);
        use3(8'h21, 8'h30, 8'h30);
        checkWord({29'h0, pauseReq}, 32'h00000007);
        checkWord({29'h0, activePorts}, 32'h00000006);
        use3(8'h03, 8'h30, 8'h30);
        checkWord({29'h0, pauseReq}, 32'h00000006);
        repeat (4) @(posedge clk_sys);
        checkWord(expPkt.size() + expRd.size(), 32'h00000000);
        results();
    end
endmodule : test_sbm_csrs
